// file: sim/lsf_mem_model.sv
// External memory model that supplies read data for the frame DMA.
`timescale 1ns/1ps
module lsf_mem_model (
   input wire logic clk_i,
   output logic [31:0] rdata_o
);
   // The data changes every cycle, so a late or stale capture is seen.
   initial rdata_o = 32'h0000_0000;
   always @(posedge clk_i) begin
      rdata_o <= {rdata_o[30:0], ~rdata_o[31]};
   end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the display status flag bank.
`timescale 1ns/1ps
module tb_top;
   import lsf_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic tog = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, mem, dma_rd, q, cap, clr, expv;
   logic [31:0] seed = 32'h5e0e0da4;
   logic ack, hold, dual, irq;
   lsf_fifo_ev_t fev = '0;
   lsf_dma_ev_t dev = '0;
   int fails = 0;
   int n_checks = 0;
   int cyc_n = 0;

   always #50 clk_i = ~clk_i;

   lsf_mem_model mem_model (.clk_i(clk_i), .rdata_o(mem));
   lsf_status_flags uut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fifo_ev_i(fev),
      .dma_ev_i(dev), .mem_rdata_i(mem), .dma_rdata_o(dma_rd),
      .bias_toggle_i(tog), .bias_hold_o(hold), .dual_panel_o(dual),
      .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [31:0] fifo_bits(input logic [7:0] f,
                                             input logic two);
      return {20'h0, f, 4'h0} & (two ? 32'hffff_ffff : 32'hffff_fccf);
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Read data is taken at the rising edge that samples ack high; the
   // task returns after the falling edge so that outputs have settled.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(negedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic ev(input lsf_fifo_ev_t f, input lsf_dma_ev_t d,
                     input logic t);
      @(posedge clk_i);
      fev <= f;
      dev <= d;
      tog <= t;
      @(posedge clk_i);
      cap = mem;
      fev <= '0;
      dev <= '0;
      tog <= 1'b0;
   endtask

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         fails++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      rchk(8'h00, 32'h0000_0200);
      rchk(8'h04, 32'h0);
      rchk(8'h0c, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      ev(8'hff, 3'b000, 1'b0);
      rchk(8'h04, fifo_bits(8'hff, 1'b0));
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 8'h04, 32'hffff_f003);
      rchk(8'h04, 32'h0000_0cc0);
      bus(1'b1, 8'h08, 32'hffff_ffff);
      rchk(8'h08, 32'h0000_0ffc);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h04, 32'h0000_0cc0);
      rchk(8'h04, 32'h0);
      bus(1'b1, 8'h00, 32'h0000_0100);
      chk({31'h0, dual}, 32'h1);
      expv = 32'h0;
      repeat (10) begin
         seed = lfsr(seed);
         ev(seed[7:0], 3'b000, 1'b0);
         expv = expv | fifo_bits(seed[7:0], 1'b1);
         rchk(8'h04, expv);
         chk({31'h0, irq}, {31'h0, |expv});
         clr = seed & 32'h0000_0ff0;
         bus(1'b1, 8'h04, clr);
         expv = expv & ~clr;
         rchk(8'h04, expv);
      end
      ev(8'h01, 3'b000, 1'b0);
      bus(1'b1, 8'h00, 32'h0000_0300);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h04, 32'h0000_0ffc);
      bus(1'b1, 8'h00, 32'h0000_0103);
      ev('0, 3'b111, 1'b0);
      @(negedge clk_i);
      chk(dma_rd, 32'h0);
      rchk(8'h04, 32'h0000_0004);
      ev('0, 3'b110, 1'b0);
      @(negedge clk_i);
      chk(dma_rd, cap);
      bus(1'b1, 8'h04, 32'h0000_0004);
      repeat (2) ev('0, '0, 1'b1);
      rchk(8'h04, 32'h0);
      ev('0, '0, 1'b1);
      rchk(8'h04, 32'h0000_0008);
      chk({31'h0, hold}, 32'h1);
      repeat (3) ev('0, '0, 1'b1);
      bus(1'b1, 8'h04, 32'h0000_0008);
      repeat (2) ev('0, '0, 1'b1);
      rchk(8'h04, 32'h0);
      ev('0, '0, 1'b1);
      rchk(8'h04, 32'h0000_0008);
      bus(1'b1, 8'h00, 32'h0000_0100);
      rchk(8'h04, 32'h0);
      repeat (4) ev('0, '0, 1'b1);
      rchk(8'h04, 32'h0);
      summarize();
   end
endmodule

// file: src/lsf_bias_counter.sv
// Bias transition counter: counts pin toggles down from the interval.
`timescale 1ns/1ps
module lsf_bias_counter #(
   parameter int API_W = 8
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [API_W-1:0] interval_i,
   input wire logic toggle_i,
   input wire logic hold_i,
   output logic expire_o
);

   logic [API_W-1:0] count;
   wire logic active;
   wire logic [API_W-1:0] next_count;

   assign active = (interval_i != '0) && !hold_i && (count != '0);
   assign expire_o = active && toggle_i && (count == API_W'(1));

   // Zero count means freshly enabled; it loads before counting.
   assign next_count = (interval_i == '0) ? '0 :
                       (hold_i || count == '0 || expire_o) ? interval_i :
                       (active && toggle_i) ? count - API_W'(1) :
                       count;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// file: src/lsf_defines.svh
// Register offsets, field positions and reset values of the status flag bank.
// Operation
// - Bad DMA address sets bus error flag.
// - DMA reads of bad addresses return zeros.
// - Bias counter reaching zero sets bias flag.
// - Bias flag held clear while interval zero.
// - Expired bias counter reloads, halts until cleared.
// - Lower input FIFO overrun sets bit 4.
// - Lower input FIFO underrun sets bit 5.
// - Upper input FIFO overrun sets bit 6.
// - Upper input FIFO underrun sets bit 7.
// - Lower output FIFO overrun sets bit 8.
// - Lower output FIFO underrun sets bit 9.
// - Upper output FIFO overrun sets bit 10.
// - Upper output FIFO underrun sets bit 11.
// - Writing one clears flag; zero leaves it.
// - Set flag with mask zero raises interrupt, only while control bit 9 is clear (it resets to one).
// - Lower panel flags only in dual panel.
// - Reserved status bits ignore writes, read zero.
`ifndef LSF_DEFINES_SVH
`define LSF_DEFINES_SVH

`define LSF_CTRL_OFF 8'h00
`define LSF_STATUS_OFF 8'h04
`define LSF_MASK_OFF 8'h08

`define LSF_FLAG_LSB 2
`define LSF_FLAG_MSB 11
`define LSF_BIT_BUS_ERR 2
`define LSF_BIT_BIAS 3
`define LSF_BIT_FIFO_LSB 4

`define LSF_CTRL_DUAL 8
`define LSF_CTRL_ERM 9

`define LSF_CTRL_RST 32'h0000_0200
`define LSF_MASK_RST 32'h0000_0000
`define LSF_FLAGS_VALID 32'h0000_0ffc
`define LSF_LOWER_FLAGS 32'h0000_0330

`endif

// file: src/lsf_flag.sv
// One sticky status flag: hardware sets, software clears by writing one.
`timescale 1ns/1ps
module lsf_flag (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic set_i,
   input wire logic clr_i,
   input wire logic force_clr_i,
   output logic flag_o
);

   wire logic next_flag;

   // A set in a write-one clearing cycle wins, so no event is lost; a forced clear beats the set.
   assign next_flag = force_clr_i ? 1'b0 :
                      set_i ? 1'b1 :
                      clr_i ? 1'b0 : flag_o;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else begin
         flag_o <= next_flag;
      end
   end

endmodule

// file: src/lsf_pkg.sv
// Types shared by the status flag bank and its users.
package lsf_pkg;

   // Bit order matches the status register, bit 11 down to bit 4.
   typedef struct packed {
      logic out_underrun_upper;
      logic out_overrun_upper;
      logic out_underrun_lower;
      logic out_overrun_lower;
      logic in_underrun_upper;
      logic in_overrun_upper;
      logic in_underrun_lower;
      logic in_overrun_lower;
   } lsf_fifo_ev_t;

   typedef struct packed {
      logic req;
      logic rd;
      logic bad;
   } lsf_dma_ev_t;

endpackage

// file: src/lsf_status_flags.sv
// Display status flag bank with Wishbone register access and interrupt.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`include "lsf_defines.svh"
`timescale 1ns/1ps
module lsf_status_flags #(
   parameter int ADR_W = 8,
   parameter int API_W = 8
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire lsf_pkg::lsf_fifo_ev_t fifo_ev_i,
   input wire lsf_pkg::lsf_dma_ev_t dma_ev_i,
   input wire logic [31:0] mem_rdata_i,
   output logic [31:0] dma_rdata_o,
   input wire logic bias_toggle_i,
   output logic bias_hold_o,
   output logic dual_panel_o,
   output logic irq_o
);
   import lsf_pkg::*;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic [31:0] ctrl;
   logic [31:0] flag_mask;
   wire logic [31:0] flags;
   wire logic req;
   wire logic bus_write;
   wire logic hit_ctrl;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic [31:0] lane_mask;
   wire logic [31:0] rdata;
   wire logic status_wr;

   assign req = wb_cyc_i && wb_stb_i;
   // Writes act on the edge where ack is seen, as the master samples it.
   assign bus_write = req && wb_we_i && wb_ack_o;
   assign hit_ctrl = wb_adr_i == ADR_W'(`LSF_CTRL_OFF);
   assign hit_status = wb_adr_i == ADR_W'(`LSF_STATUS_OFF);
   assign hit_mask = wb_adr_i == ADR_W'(`LSF_MASK_OFF);
   assign status_wr = bus_write && hit_status;
   assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // Unmapped addresses still ack so the master never hangs; they read 0.
   assign rdata = hit_ctrl ? ctrl :
                  hit_status ? flags :
                  hit_mask ? flag_mask : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
         wb_dat_o <= (req && !wb_ack_o) ? rdata : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and mask registers.

   wire logic [31:0] next_ctrl;
   wire logic [31:0] next_mask;
   wire logic [API_W-1:0] bias_interval;
   wire logic dual_panel_select;
   wire logic error_int_mask;

   assign next_ctrl = (ctrl & ~lane_mask) | (wb_dat_i & lane_mask);
   assign next_mask = ((flag_mask & ~lane_mask) | (wb_dat_i & lane_mask))
                      & `LSF_FLAGS_VALID;
   assign bias_interval = ctrl[API_W-1:0];
   assign dual_panel_select = ctrl[`LSF_CTRL_DUAL];
   assign error_int_mask = ctrl[`LSF_CTRL_ERM];

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ctrl <= `LSF_CTRL_RST;
         flag_mask <= `LSF_MASK_RST;
      end else begin
         if (bus_write && hit_ctrl) begin
            ctrl <= next_ctrl;
         end
         if (bus_write && hit_mask) begin
            flag_mask <= next_mask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event sources.

   wire logic bias_expire;
   wire logic [31:0] set_vec;
   wire logic [31:0] clr_vec;
   wire logic [31:0] force_vec;
   wire logic [31:0] fifo_set;
   wire logic [31:0] panel_gate;

   lsf_bias_counter #(
      .API_W(API_W)
   ) u_bias (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .interval_i(bias_interval),
      .toggle_i(bias_toggle_i),
      .hold_i(flags[`LSF_BIT_BIAS]),
      .expire_o(bias_expire)
   );

   // Lower panel events only count when two panels are driven.
   assign panel_gate = dual_panel_select ? 32'hffff_ffff :
                       ~`LSF_LOWER_FLAGS;
   // Struct order maps straight onto bits 11..4
   assign fifo_set = ({20'h00000, fifo_ev_i, 4'h0}) & panel_gate;
   assign set_vec = fifo_set
                  | (32'(bias_expire) << `LSF_BIT_BIAS)
                  | (32'(dma_ev_i.req && dma_ev_i.bad)
                     << `LSF_BIT_BUS_ERR);
   assign clr_vec = status_wr ? (wb_dat_i & lane_mask) : 32'h0000_0000;
   assign force_vec = (bias_interval == '0) ?
                      (32'h0000_0001 << `LSF_BIT_BIAS) : 32'h0000_0000;

   // Each flag bit, 2 to 11, gets its own sticky cell; the other status bits are tied to zero.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_bit
         if (gi >= `LSF_FLAG_LSB && gi <= `LSF_FLAG_MSB) begin : g_flag
            lsf_flag u_flag (
               .clk_i(clk_i),
               .rstn_i(rstn_i),
               .set_i(set_vec[gi]),
               .clr_i(clr_vec[gi]),
               .force_clr_i(force_vec[gi]),
               .flag_o(flags[gi])
            );
         end else begin : g_resv
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate

   // Named views of the flags, in status register order.
   wire logic bus_error_flag;
   wire logic bias_count_flag;
   wire lsf_fifo_ev_t fifo_flags;

   assign bus_error_flag = flags[`LSF_BIT_BUS_ERR];
   assign bias_count_flag = flags[`LSF_BIT_BIAS];
   assign fifo_flags = flags[`LSF_FLAG_MSB:`LSF_BIT_FIFO_LSB];

   ////////////////////////////////////////////////////////////////////////
   // DMA read data and outputs.

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         dma_rdata_o <= 32'h0000_0000;
      end else if (dma_ev_i.rd) begin
         dma_rdata_o <= dma_ev_i.bad ? 32'h0000_0000 : mem_rdata_i;
      end
   end

   assign bias_hold_o = flags[`LSF_BIT_BIAS];
   assign dual_panel_o = dual_panel_select;
   assign irq_o = !error_int_mask && |(flags & ~flag_mask);

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_bus_err_set: assert property (
      dma_ev_i.req && dma_ev_i.bad |=> flags[`LSF_BIT_BUS_ERR])
      else $error("bus error flag not set after bad access");

   a_dma_zero_read: assert property (
      dma_ev_i.rd && dma_ev_i.bad |=> dma_rdata_o == 32'h0000_0000)
      else $error("bad DMA read did not return zero");

   a_bias_flag_set: assert property (
      bias_expire && bias_interval != '0 |=> flags[`LSF_BIT_BIAS])
      else $error("bias flag not set on expiry");

   a_bias_zero_clear: assert property (
      bias_interval == '0 |=> !flags[`LSF_BIT_BIAS])
      else $error("bias flag set with zero interval");

   a_bias_held: assert property (
      bias_expire |=> bias_count_flag
      && u_bias.count == $past(bias_interval))
      else $error("bias counter not reloaded on expiry");

   a_fifo_flag_set: assert property (
      fifo_set != 0 |=> (flags & $past(fifo_set)) == $past(fifo_set))
      else $error("FIFO event did not set its flag");

   a_lower_gated: assert property (
      !dual_panel_select |=>
      (flags & ~$past(flags) & `LSF_LOWER_FLAGS) == 32'h0000_0000)
      else $error("lower panel flag set in single panel mode");

   a_w1c_clear: assert property (
      status_wr && wb_dat_i[6] && wb_sel_i[0] && !set_vec[6] |=> !flags[6])
      else $error("write one did not clear flag");

   a_flags_sticky: assert property (
      !status_wr && bias_interval != '0 |=>
      (flags & $past(flags)) == $past(flags))
      else $error("flag dropped without a clear");

   a_irq_follow: assert property (
      |(set_vec & ~flag_mask) && !error_int_mask && !bus_write |=> irq_o)
      else $error("unmasked flag raised no interrupt");

   a_resv_zero: assert property (
      req && !wb_we_i && !wb_ack_o && hit_status |=>
      wb_dat_o[31:12] == 20'h00000 && wb_dat_o[1:0] == 2'b00)
      else $error("reserved status bits read nonzero");

   // One check per FIFO flag; the lower four only count with two panels.
   a_in_ovr_lower: assert property (
      dual_panel_select && fifo_ev_i.in_overrun_lower
      |=> fifo_flags.in_overrun_lower)
      else $error("lower input overrun flag not set");

   a_in_und_lower: assert property (
      dual_panel_select && fifo_ev_i.in_underrun_lower
      |=> fifo_flags.in_underrun_lower)
      else $error("lower input underrun flag not set");

   a_in_ovr_upper: assert property (
      fifo_ev_i.in_overrun_upper |=> fifo_flags.in_overrun_upper)
      else $error("upper input overrun flag not set");

   a_in_und_upper: assert property (
      fifo_ev_i.in_underrun_upper |=> fifo_flags.in_underrun_upper)
      else $error("upper input underrun flag not set");

   a_out_ovr_lower: assert property (
      dual_panel_select && fifo_ev_i.out_overrun_lower
      |=> fifo_flags.out_overrun_lower)
      else $error("lower output overrun flag not set");

   a_out_und_lower: assert property (
      dual_panel_select && fifo_ev_i.out_underrun_lower
      |=> fifo_flags.out_underrun_lower)
      else $error("lower output underrun flag not set");

   a_out_ovr_upper: assert property (
      fifo_ev_i.out_overrun_upper |=> fifo_flags.out_overrun_upper)
      else $error("upper output overrun flag not set");

   a_out_und_upper: assert property (
      fifo_ev_i.out_underrun_upper |=> fifo_flags.out_underrun_upper)
      else $error("upper output underrun flag not set");

   a_dma_pass: assert property (
      dma_ev_i.rd && !dma_ev_i.bad |=> dma_rdata_o == $past(mem_rdata_i))
      else $error("good DMA read data not passed on");

   a_dma_hold: assert property (
      !dma_ev_i.rd |=> $stable(dma_rdata_o))
      else $error("DMA read data changed without a read");

   // A zero interval parks the counter, so toggles then are not counted.
   a_bias_quiet: assert property (
      bias_interval == '0 |-> !bias_expire)
      else $error("bias counter expired with zero interval");

   a_bias_idle: assert property (
      bias_interval == '0 |=> u_bias.count == '0)
      else $error("bias counter not parked with zero interval");

   a_bus_err_keep: assert property (
      bus_error_flag && !(status_wr && wb_dat_i[2] && wb_sel_i[0])
      |=> bus_error_flag)
      else $error("bus error flag dropped without a clear");

   a_bias_keep: assert property (
      bias_count_flag && bias_interval != '0
      && !(status_wr && wb_dat_i[3] && wb_sel_i[0]) |=> bias_count_flag)
      else $error("bias flag dropped without a clear");

   a_zero_keeps: assert property (
      status_wr && !wb_dat_i[11] && fifo_flags.out_underrun_upper
      |=> fifo_flags.out_underrun_upper)
      else $error("writing zero cleared a flag");

   a_lane_keeps: assert property (
      status_wr && !wb_sel_i[1] && fifo_flags.out_underrun_upper
      |=> fifo_flags.out_underrun_upper)
      else $error("write to a disabled lane cleared a flag");

   a_irq_off: assert property (
      error_int_mask |-> !irq_o)
      else $error("interrupt raised while interrupts are off");

   a_irq_on: assert property (
      !error_int_mask && (flags & ~flag_mask) != 32'h0000_0000 |-> irq_o)
      else $error("interrupt low with an unmasked flag set");

   a_mask_write: assert property (
      bus_write && hit_mask && wb_sel_i == 4'hf
      |=> flag_mask == ($past(wb_dat_i) & `LSF_FLAGS_VALID))
      else $error("mask write did not land");

   // Register bus: one-cycle answer, read data only beside ack.
   a_ack_answer: assert property (
      req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");

   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

   a_dat_idle: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data nonzero outside ack");

   a_unmapped_zero: assert property (
      req && !wb_ack_o && !hit_ctrl && !hit_status && !hit_mask
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped address read nonzero");

   a_ctrl_write: assert property (
      bus_write && hit_ctrl && wb_sel_i == 4'hf |=> ctrl == $past(wb_dat_i))
      else $error("control write did not land");

   c_bias_expire: cover property (bias_expire ##1 flags[`LSF_BIT_BIAS]);
   c_dual_overrun: cover property (dual_panel_select && fifo_set[4]);
   c_irq_rise: cover property (!irq_o ##1 irq_o);
   c_w1c: cover property (status_wr && (wb_dat_i & flags) != 0);
   c_dma_bad: cover property (dma_ev_i.req && dma_ev_i.bad);

endmodule
